// [shared/pis_pkg.sv]
// constants and types of the phase 2 ten-bit initialization sequencer
// ----------------------------------------------------------------------
// Overview of operation
// - asynchronous mode repeats each nibble eight times, 512 transmissions in total.
// - synchronous mode repeats each nibble four times, 256 transmissions in total.
// - nibble address zero always carries protocol revision code 0100.
// - nibbles two and three carry block count 32 as 0010 then 0000.
// - nibbles six, seven send sensor type 0000, 0001; four, five send maker code.
// - nibble eight maps axis setting 00/01/10/11 to 0000/0100/1000/1100.
// - nibble nine carries range code 0111, 1000, 1001 or 1010 per variant.
// - nibbles ten to fourteen send config byte two, product revision, config six low.
// - nibbles fifteen to eighteen send year, month and day as packed julian date.
// - extended option sends offset and self-test in nibbles 27-31, else zeros.
// - nibble thirty-two sends config byte one upper bits when extended, else zero.
// - offset or self-test values are zero unless that self-test phase finished.
// - nibble ids count sixteen values, so nibble seventeen starts again at 0000.
// - each nibble is an id then a data transmission, repeated k times.
// - the message holds 32 data fields, two times k times 32 transmissions.
// ----------------------------------------------------------------------
package pis_pkg;
    // ------------------------------------------------------------------
    // message shape
    // ------------------------------------------------------------------
    localparam int          PIS_FIELDS      = 32;
    localparam logic [4:0]  PIS_LAST_IDX    = 5'h1F;
    localparam logic [2:0]  PIS_K_ASYNC     = 3'h7;   // eight repeats, minus one
    localparam logic [2:0]  PIS_K_SYNC      = 3'h3;   // four repeats, minus one
    localparam logic [9:0]  PIS_TX_ASYNC    = 10'h200;
    localparam logic [9:0]  PIS_TX_SYNC     = 10'h100;
    // ------------------------------------------------------------------
    // fixed nibble values
    // ------------------------------------------------------------------
    localparam logic [3:0]  PIS_REV_CODE    = 4'h4;
    localparam logic [3:0]  PIS_BLK_HI      = 4'h2;
    localparam logic [3:0]  PIS_BLK_LO      = 4'h0;
    localparam logic [3:0]  PIS_TYPE_HI     = 4'h0;
    localparam logic [3:0]  PIS_TYPE_LO     = 4'h1;
    localparam logic [3:0]  PIS_RANGE_60G   = 4'h7;
    localparam logic [3:0]  PIS_RANGE_120G  = 4'h8;
    localparam logic [3:0]  PIS_RANGE_240G  = 4'h9;
    localparam logic [3:0]  PIS_RANGE_480G  = 4'hA;
    localparam logic [3:0]  PIS_ZERO_NIB    = 4'h0;
    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          PIS_AW          = 8;
    localparam logic [7:0]  PIS_REG_CTRL    = 8'h00;
    localparam logic [7:0]  PIS_REG_CFG     = 8'h04;
    localparam logic [7:0]  PIS_REG_DATE    = 8'h08;
    localparam logic [7:0]  PIS_REG_SERIAL  = 8'h0C;
    localparam logic [7:0]  PIS_REG_STAT    = 8'h10;
    localparam int          PIS_CTRL_START  = 0;
    localparam int          PIS_CTRL_SYNC   = 1;
    localparam int          PIS_CTRL_EXT    = 2;
    localparam int          PIS_CTRL_AXIS   = 3;      // two bits
    localparam logic [31:0] PIS_CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] PIS_CFG_RST     = 32'h2000_0000;
    localparam logic [31:0] PIS_DATE_RST    = 32'h0000_0000;
    localparam logic [31:0] PIS_SERIAL_RST  = 32'h0000_0000;

    typedef enum logic [1:0] {PIS_IDLE, PIS_RUN, PIS_DRAIN} pis_state_t;

    typedef struct packed {
        logic       is_id;
        logic [3:0] nib;
    } pis_word_t;

    // maker [7:0], config two [15:8], config six [23:16], config one [31:24]
    typedef struct packed {
        logic [7:0] cfg1;
        logic [7:0] cfg6;
        logic [7:0] cfg2;
        logic [7:0] maker;
    } pis_cfg_t;

    // year [6:0], month [10:7], day [15:11]
    typedef struct packed {
        logic [15:0] rsvd;
        logic [4:0]  day;
        logic [3:0]  month;
        logic [6:0]  year;
    } pis_date_t;

    typedef struct packed {
        logic [9:0] offset;
        logic       offset_ok;
        logic [9:0] avg;
        logic       avg_ok;
    } pis_st_t;
endpackage

// [verilog/pis_init2_seq.sv]
// phase 2 ten-bit initialization message sequencer with register port and output buffer
`timescale 1ns/1ps
module pis_init2_seq
    import pis_pkg::*;
#(
    parameter logic [3:0] RANGE_CODE  = PIS_RANGE_120G,
    parameter logic [3:0] PROD_REV_HI = 4'h0,   // arbitrary factory value
    parameter logic [3:0] PROD_REV_LO = 4'h0    // arbitrary factory value
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic [PIS_AW-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rdata,
    input  wire pis_st_t           i_selftest,
    output pis_word_t              o_tx,
    output logic                   o_tx_valid,
    input  wire logic              i_tx_ready,
    output logic                   o_busy,
    output logic                   o_done
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pis_state_t  st;
        logic [4:0]  idx;
        logic [2:0]  rep;
        logic        half;
        logic        done;
        logic        done_p;
        logic        sync;
        logic        ext;
        logic [1:0]  axis;
        pis_cfg_t    cfg;
        pis_date_t   date;
        logic [31:0] serial;
        logic [31:0] rdata;
        pis_word_t   e0;
        pis_word_t   e1;
        logic [1:0]  cnt;
    } pis_regs_t;

    pis_regs_t s_q;
    pis_regs_t s_d;
    pis_word_t w;
    logic      room;
    logic      push;
    logic      pop;
    logic      start;
    logic [2:0] k_last;

    assign room   = (s_q.cnt != 2'h2);
    assign push   = (s_q.st == PIS_RUN) && room;
    assign pop    = (s_q.cnt != 2'h0) && i_tx_ready;
    assign start  = i_wr && (i_addr == PIS_REG_CTRL) && i_wdata[PIS_CTRL_START]
                    && (s_q.st == PIS_IDLE);
    assign k_last = s_q.sync ? PIS_K_SYNC : PIS_K_ASYNC;

    // ------------------------------------------------------------------
    // data nibble per address
    // ------------------------------------------------------------------
    function automatic logic [3:0] nib_of(input logic [4:0] idx, input pis_regs_t s,
                                          input pis_st_t t);
        logic [3:0] v;
        logic       okd;
        logic       oka;
        v   = PIS_ZERO_NIB;
        okd = s.ext && t.offset_ok;
        oka = s.ext && t.avg_ok;
        case (idx)
            5'd0:  v = PIS_REV_CODE;
            5'd1:  v = PIS_BLK_HI;
            5'd2:  v = PIS_BLK_LO;
            5'd3:  v = s.cfg.maker[7:4];
            5'd4:  v = s.cfg.maker[3:0];
            5'd5:  v = PIS_TYPE_HI;
            5'd6:  v = PIS_TYPE_LO;
            5'd7:  v = {s.axis, 2'b00};
            5'd8:  v = RANGE_CODE;
            5'd9:  v = s.cfg.cfg2[7:4];
            5'd10: v = s.cfg.cfg2[3:0];
            5'd11: v = PROD_REV_HI;
            5'd12: v = PROD_REV_LO;
            5'd13: v = s.cfg.cfg6[3:0];
            5'd14: v = s.date.year[6:3];
            5'd15: v = {s.date.year[2:0], s.date.month[3]};
            5'd16: v = {s.date.month[2:0], s.date.day[4]};
            5'd17: v = s.date.day[3:0];
            5'd18: v = s.serial[7:4];
            5'd19: v = s.serial[3:0];
            5'd20: v = s.serial[15:12];
            5'd21: v = s.serial[11:8];
            5'd22: v = s.serial[23:20];
            5'd23: v = s.serial[19:16];
            5'd24: v = s.serial[31:28];
            5'd25: v = s.serial[27:24];
            5'd26: v = okd ? t.offset[3:0] : PIS_ZERO_NIB;
            5'd27: v = okd ? t.offset[7:4] : PIS_ZERO_NIB;
            5'd28: v = {oka ? t.avg[1:0] : 2'b00,
                        okd ? t.offset[9:8] : 2'b00};
            5'd29: v = oka ? t.avg[5:2] : PIS_ZERO_NIB;
            5'd30: v = oka ? t.avg[9:6] : PIS_ZERO_NIB;
            default: v = s.ext ? s.cfg.cfg1[7:4] : PIS_ZERO_NIB;
        endcase
        return v;
    endfunction

    // id transmission first, then data; ids wrap after sixteen
    assign w.is_id = !s_q.half;
    assign w.nib   = s_q.half ? nib_of(s_q.idx, s_q, i_selftest)
                              : s_q.idx[3:0];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.done_p = 1'b0;
        s_d.rdata  = 32'h0000_0000;
        // register writes
        if (i_wr) begin
            if (i_addr == PIS_REG_CTRL) begin
                if (s_q.st == PIS_IDLE) begin
                    s_d.sync = i_wdata[PIS_CTRL_SYNC];
                    s_d.ext  = i_wdata[PIS_CTRL_EXT];
                    s_d.axis = i_wdata[PIS_CTRL_AXIS +: 2];
                end
            end else if (i_addr == PIS_REG_CFG) begin
                s_d.cfg = i_wdata;
            end else if (i_addr == PIS_REG_DATE) begin
                s_d.date = {16'h0000, i_wdata[15:0]};
            end else if (i_addr == PIS_REG_SERIAL) begin
                s_d.serial = i_wdata;
            end
        end
        // register reads, answered next cycle
        if (i_rd) begin
            if (i_addr == PIS_REG_CTRL) begin
                s_d.rdata = {27'h0, s_q.axis, s_q.ext, s_q.sync, 1'b0};
            end else if (i_addr == PIS_REG_CFG) begin
                s_d.rdata = s_q.cfg;
            end else if (i_addr == PIS_REG_DATE) begin
                s_d.rdata = s_q.date;
            end else if (i_addr == PIS_REG_SERIAL) begin
                s_d.rdata = s_q.serial;
            end else if (i_addr == PIS_REG_STAT) begin
                s_d.rdata = {23'h0, i_selftest.avg_ok, i_selftest.offset_ok,
                             s_q.idx, s_q.done, s_q.st != PIS_IDLE};
            end
        end
        // sequencer
        case (s_q.st)
            PIS_IDLE: begin
                if (start) begin
                    s_d.st   = PIS_RUN;
                    s_d.idx  = 5'h00;
                    s_d.rep  = 3'h0;
                    s_d.half = 1'b0;
                    s_d.done = 1'b0;
                end
            end
            PIS_RUN: begin
                if (push) begin
                    s_d.half = !s_q.half;
                    if (s_q.half) begin
                        if (s_q.rep == k_last) begin
                            s_d.rep = 3'h0;
                            s_d.idx = 5'(s_q.idx + 5'h01);
                            if (s_q.idx == PIS_LAST_IDX) begin
                                s_d.st = PIS_DRAIN;
                            end
                        end else begin
                            s_d.rep = 3'(s_q.rep + 3'h1);
                        end
                    end
                end
            end
            PIS_DRAIN: begin
                if (s_q.cnt == 2'h0) begin
                    s_d.st     = PIS_IDLE;
                    s_d.done   = 1'b1;
                    s_d.done_p = 1'b1;
                end
            end
            default: s_d.st = PIS_IDLE;
        endcase
        // two-entry buffer, head in e0
        if (push && pop) begin
            if (s_q.cnt == 2'h1) begin
                s_d.e0 = w;
            end else begin
                s_d.e0 = s_q.e1;
                s_d.e1 = w;
            end
        end else if (pop) begin
            s_d.e0  = s_q.e1;
            s_d.cnt = 2'(s_q.cnt - 2'h1);
        end else if (push) begin
            if (s_q.cnt == 2'h0) begin
                s_d.e0 = w;
            end else begin
                s_d.e1 = w;
            end
            s_d.cnt = 2'(s_q.cnt + 2'h1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.cfg <= PIS_CFG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata    = s_q.rdata;
    assign o_tx       = s_q.e0;
    assign o_tx_valid = (s_q.cnt != 2'h0);
    assign o_busy     = (s_q.st != PIS_IDLE);
    assign o_done     = s_q.done_p;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [9:0] n_tx_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || start) begin
            n_tx_q <= 10'h000;
        end else if (o_tx_valid && i_tx_ready) begin
            n_tx_q <= 10'(n_tx_q + 10'h001);
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    chk_async_total: assert property (o_done && !s_q.sync |-> n_tx_q == PIS_TX_ASYNC)
        else $error("async message length wrong");
    chk_sync_total: assert property (o_done && s_q.sync |-> n_tx_q == PIS_TX_SYNC)
        else $error("sync message length wrong");
    chk_rep_bound: assert property (s_q.st == PIS_RUN |-> s_q.rep <= k_last)
        else $error("repeat count beyond k");
    chk_rev_code: assert property (push && !w.is_id && s_q.idx == 5'd0
        |-> w.nib == 4'h4)
        else $error("revision nibble wrong");
    chk_block_count: assert property (push && !w.is_id && s_q.idx == 5'd1
        |-> w.nib == 4'h2)
        else $error("block count nibble wrong");
    chk_maker_high: assert property (push && !w.is_id && s_q.idx == 5'd3
        |-> w.nib == s_q.cfg.maker[7:4])
        else $error("maker nibble wrong");
    chk_type_low: assert property (push && !w.is_id && s_q.idx == 5'd6
        |-> w.nib == 4'h1)
        else $error("sensor type nibble wrong");
    chk_axis_map: assert property (push && !w.is_id && s_q.idx == 5'd7
        |-> w.nib == ((s_q.axis == 2'b00) ? 4'h0 : (s_q.axis == 2'b01) ? 4'h4
                    : (s_q.axis == 2'b10) ? 4'h8 : 4'hC))
        else $error("axis nibble wrong");
    chk_range_code: assert property (push && !w.is_id && s_q.idx == 5'd8
        |-> w.nib == RANGE_CODE)
        else $error("range nibble wrong");
    chk_cfg_two: assert property (push && !w.is_id && s_q.idx == 5'd9
        |-> w.nib == s_q.cfg.cfg2[7:4])
        else $error("config two nibble wrong");
    chk_cfg_six: assert property (push && !w.is_id && s_q.idx == 5'd13
        |-> w.nib == s_q.cfg.cfg6[3:0])
        else $error("config six nibble wrong");
    chk_date_year: assert property (push && !w.is_id && s_q.idx == 5'd14
        |-> w.nib == s_q.date.year[6:3])
        else $error("year nibble wrong");
    chk_serial_first: assert property (push && !w.is_id && s_q.idx == 5'd18
        |-> w.nib == s_q.serial[7:4])
        else $error("first serial nibble wrong");
    chk_serial_last: assert property (push && !w.is_id && s_q.idx == 5'd25
        |-> w.nib == s_q.serial[27:24])
        else $error("last serial nibble wrong");
    chk_ext_zero: assert property (push && !w.is_id && !s_q.ext && s_q.idx >= 5'd26
        |-> w.nib == 4'h0)
        else $error("extended nibble not zero");
    chk_last_nibble: assert property (push && !w.is_id && s_q.ext && s_q.idx == 5'd31
        |-> w.nib == s_q.cfg.cfg1[7:4])
        else $error("last nibble wrong");
    chk_offset_gate: assert property (push && !w.is_id && !i_selftest.offset_ok
        && s_q.idx == 5'd26 |-> w.nib == 4'h0)
        else $error("offset sent before ready");
    chk_avg_gate: assert property (push && !w.is_id && !i_selftest.avg_ok
        && s_q.idx == 5'd30 |-> w.nib == 4'h0)
        else $error("self-test sent before ready");
    chk_id_page: assert property (push && w.is_id |-> w.nib == s_q.idx[3:0])
        else $error("nibble id wrong");
    chk_pair_order: assert property (o_tx_valid && i_tx_ready && o_tx.is_id
        |=> !o_tx_valid || !o_tx.is_id)
        else $error("id not followed by data");
    chk_buf_hold: assert property (o_tx_valid && !i_tx_ready
        |=> o_tx_valid && $stable(o_tx))
        else $error("buffer head lost while stalled");
    chk_drain_wrap: assert property ($rose(s_q.st == PIS_DRAIN)
        |-> s_q.idx == 5'd0 && s_q.rep == 3'h0)
        else $error("message did not end after 32 nibbles");
    chk_done_end: assert property ($rose(s_q.st == PIS_DRAIN)
        |-> ##[1:600] o_done)
        else $error("completion not signalled");
    chk_done_empty: assert property (o_done |-> !o_tx_valid && !o_busy)
        else $error("completion before buffer empty");
endmodule

// [test/pis_rx_model.sv]
// far-side receiver model: takes transmit words, optionally stalling
`timescale 1ns/1ps
module pis_rx_model
    import pis_pkg::*;
(
    input  wire logic      i_sys_clk,
    input  wire logic      i_rst_n,
    input  wire logic      i_clear,
    input  wire logic      i_stall,
    input  wire pis_word_t i_tx,
    input  wire logic      i_tx_valid,
    output logic           o_tx_ready
);
    pis_word_t  words [0:511];
    int         count;
    logic [1:0] ph_q;
    // ------------------------------------------------------------------
    // capture; when stalling, ready only one cycle in four
    // ------------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (!i_rst_n || i_clear) begin
            count      <= 0;
            ph_q       <= 2'h0;
            o_tx_ready <= 1'b0;
        end else begin
            ph_q       <= ph_q + 2'h1;
            o_tx_ready <= !i_stall || (ph_q == 2'h3);
            if (i_tx_valid && o_tx_ready) begin
                if (count < 512) words[count] <= i_tx;
                count <= count + 1;
            end
        end
    end
endmodule

// [test/test_pis_init2_seq.sv]
// self-checking bench for the phase 2 sequencer
`timescale 1ns/1ps
module test_pis_init2_seq;
    import pis_pkg::*;
    logic [PIS_AW-1:0] addr;
    logic [31:0]       wdata, rdata, sn;
    logic              clk, rst_n, wr, rd, tx_valid, tx_ready, busy, done, stall, clr;
    pis_st_t           st;
    pis_word_t         tx;
    pis_cfg_t          cf;
    pis_date_t         dt;
    logic [3:0]        exp_nib [0:31];
    int                failures, checks;

    pis_init2_seq #(.RANGE_CODE(PIS_RANGE_240G), .PROD_REV_HI(4'hC), .PROD_REV_LO(4'h3)) dut_u (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_selftest(st), .o_tx(tx), .o_tx_valid(tx_valid),
        .i_tx_ready(tx_ready), .o_busy(busy), .o_done(done));
    pis_rx_model rx_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clear(clr), .i_stall(stall),
        .i_tx(tx), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));

    always #25 clk = ~clk;
    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task give_verdict;
        if (failures == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic build_exp(input logic ext, input logic [1:0] axis, input pis_st_t s);
        logic [9:0] o;
        logic [9:0] a;
        o = (ext && s.offset_ok) ? s.offset : 10'h0;
        a = (ext && s.avg_ok) ? s.avg : 10'h0;
        exp_nib = '{4'h4, 4'h2, 4'h0, cf.maker[7:4], cf.maker[3:0], 4'h0, 4'h1,
            {axis, 2'b00}, 4'h9, cf.cfg2[7:4], cf.cfg2[3:0], 4'hC, 4'h3, cf.cfg6[3:0],
            dt.year[6:3], {dt.year[2:0], dt.month[3]}, {dt.month[2:0], dt.day[4]},
            dt.day[3:0], sn[7:4], sn[3:0], sn[15:12], sn[11:8], sn[23:20], sn[19:16],
            sn[31:28], sn[27:24], o[3:0], o[7:4], {a[1:0], o[9:8]}, a[5:2], a[9:6],
            ext ? cf.cfg1[7:4] : 4'h0};
    endtask
    // one whole message; poke rewrites control while busy
    task automatic run_msg(input logic sync, input logic ext, input logic [1:0] axis,
                           input logic stl, input pis_st_t s, input logic poke);
        int k;
        int n;
        int w;
        logic [31:0] v;
        @(posedge clk);
        stall <= stl;
        st    <= s;
        clr   <= 1'b1;
        @(posedge clk);
        clr   <= 1'b0;
        build_exp(ext, axis, s);
        reg_wr(PIS_REG_CFG, cf);
        reg_wr(PIS_REG_DATE, dt);
        reg_wr(PIS_REG_SERIAL, sn);
        reg_wr(PIS_REG_CTRL, {27'h0, axis, ext, sync, 1'b1});
        #1;
        check({31'h0, busy}, 32'h1, "busy during run");
        if (poke) reg_wr(PIS_REG_CTRL, {27'h0, ~axis, 1'b0, ~sync, 1'b1});
        w = 0;
        while (done !== 1'b1 && w < 20000) begin
            @(posedge clk);
            #1;
            w++;
        end
        if (w >= 20000) begin
            failures++;
            give_verdict;
        end
        k = sync ? 4 : 8;
        check(32'(rx_u.count), 32'(2 * k * 32), "word count");
        for (int i = 0; i < 2 * k * 32; i++) begin
            n = i / (2 * k);
            v = (i % 2 == 0) ? {27'h0, 1'b1, n[3:0]} : {27'h0, 1'b0, exp_nib[n]};
            check({27'h0, rx_u.words[i]}, v, "word");
        end
        @(posedge clk);
        #1;
        check({31'h0, done}, 32'h0, "done width");
        check({31'h0, busy}, 32'h0, "busy after run");
        reg_rd(PIS_REG_STAT, v);
        check({23'h0, v[8:0]}, {23'h0, s.avg_ok, s.offset_ok, 7'h02}, "status done");
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_regs;
        logic [31:0] v;
        reg_rd(PIS_REG_CFG, v);
        check(v, 32'h2000_0000, "cfg reset");
        reg_rd(PIS_REG_CTRL, v);
        check(v, 32'h0, "ctrl reset");
        reg_rd(PIS_REG_STAT, v);
        check(v, 32'h0, "stat reset");
        reg_rd(8'h14, v);
        check(v, 32'h0, "unmapped read");
    endtask
    task automatic test_async_plain;
        cf = 32'h20A5_3C96;
        dt = {16'h0, 5'h1B, 4'hC, 7'h55};
        sn = 32'h8765_4321;
        run_msg(1'b0, 1'b0, 2'h1, 1'b0, {10'h2D7, 1'b1, 10'h1B9, 1'b1}, 1'b0);
    endtask
    task automatic test_sync_stall_ext;
        cf = 32'hD45A_E17B;
        dt = {16'h0, 5'h06, 4'h3, 7'h2A};
        sn = 32'h0FED_CBA9;
        run_msg(1'b1, 1'b1, 2'h2, 1'b1, {10'h2D7, 1'b1, 10'h1B9, 1'b1}, 1'b0);
    endtask
    task automatic test_partial_selftest;
        run_msg(1'b1, 1'b1, 2'h3, 1'b0, {10'h16A, 1'b1, 10'h3C5, 1'b0}, 1'b0);
    endtask
    task automatic test_busy_write;
        run_msg(1'b1, 1'b1, 2'h0, 1'b1, {10'h16A, 1'b0, 10'h3C5, 1'b1}, 1'b1);
    endtask

    initial begin
        clk      = 1'b0;
        rst_n    = 1'b0;
        addr     = '0;
        wdata    = '0;
        wr       = 1'b0;
        rd       = 1'b0;
        st       = '0;
        stall    = 1'b0;
        clr      = 1'b0;
        failures = 0;
        checks   = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        test_reset_regs;
        test_async_plain;
        test_sync_stall_ext;
        test_partial_selftest;
        test_busy_write;
        give_verdict;
    end
endmodule
